// >>> hdl/hmw_defines.svh
// Named constants for the host memory window mailbox block.
// Assumes inclusion by bare name from every file that needs an offset or code.
`ifndef HMW_DEFINES_SVH
`define HMW_DEFINES_SVH

// Host register offsets inside the I/O window
`define HMW_OFF_H2C 4'h0
`define HMW_OFF_C2H 4'h1
`define HMW_OFF_ADDR_LO 4'h2
`define HMW_OFF_ADDR_HI 4'h3
`define HMW_OFF_DATA 2'h1
`define HMW_OFF_SRC_LO 4'h8
`define HMW_OFF_SRC_HI 4'h9
`define HMW_OFF_MASK_LO 4'ha
`define HMW_OFF_MASK_HI 4'hb
`define HMW_OFF_APPID 4'hc

// Transfer size codes held in the low address bits
`define HMW_AT_BYTE 2'h0
`define HMW_AT_HALF 2'h1
`define HMW_AT_WORD 2'h2
`define HMW_AT_AUTO 2'h3

// Data lanes
`define HMW_LANE_0 2'h0
`define HMW_LANE_1 2'h1
`define HMW_LANE_2 2'h2
`define HMW_LANE_3 2'h3
`define HMW_BE_NONE 4'h0
`define HMW_BE_LOW 4'h3
`define HMW_BE_HIGH 4'hc
`define HMW_BE_ALL 4'hf
`define HMW_BE_ONE 4'h1

// Address register fields
`define HMW_AT_MSB 1
`define HMW_WORD_MSB 14
`define HMW_WORD_LSB 2
`define HMW_REGION_BIT 15
`define HMW_WORD_ONE 13'h0001

// Interrupt source bit of the controller mailbox write
`define HMW_SRC_ECWR 0

// Reset values
`define HMW_RST_BYTE 8'h00
`define HMW_RST_HALF 16'h0000
`define HMW_RST_WORD 32'h0000_0000

`endif

// >>> hdl/hmw_pkg.sv
// Types shared by the host memory window mailbox block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package hmw_pkg;

  // One window request, held stable while it crosses to the controller clock
  typedef struct packed {
    logic we;
    logic region;
    logic [12:0] word;
    logic [3:0] be;
    logic [31:0] wdata;
  } hmw_req_s;

  // Answer to a window request
  typedef struct packed {
    logic ok;
    logic [31:0] rdata;
  } hmw_rsp_s;

  // Controller-side setting of one exposed region
  typedef struct packed {
    logic en;
    logic [31:0] base;
    logic [14:0] rd_limit;
    logic [14:0] wr_limit;
  } hmw_region_s;

  typedef enum logic [1:0] {
    HMW_IDLE = 2'b00,
    HMW_ACCESS = 2'b01,
    HMW_CAPT = 2'b10,
    HMW_REPLY = 2'b11
  } hmw_mem_e;

endpackage
`default_nettype wire

// >>> hdl/hmw_sync_bit.sv
// Two flip-flop synchroniser for one level.
// Assumes the input changes slowly compared to the destination clock.
`timescale 1ns/1ps
`default_nettype none
module hmw_sync_bit (
  input wire logic clk,
  input wire logic d,
  output logic q
);
  logic meta_r;

  // No reset: this also carries the reset itself into the link domain
  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule // hmw_sync_bit
`default_nettype wire

// >>> hdl/hmw_evt_xfer.sv
// Toggle crossing for an event with a data word between two clocks.
// Assumes events at least four destination cycles apart.
`timescale 1ns/1ps
`default_nettype none
module hmw_evt_xfer #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_pulse,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_pulse,
  output logic [W-1:0] dst_data
);
  logic tog_r;
  logic [W-1:0] hold_r;
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Data is held here so the source may change its own copy at once
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      tog_r <= 1'b0;
      hold_r <= '0;
    end else if (src_pulse) begin
      tog_r <= ~tog_r;
      hold_r <= src_data;
    end
  end

  // Toggle synchroniser; only s2 and s3 feed the edge detector
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= tog_r;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Word is stable by the time the toggle has been seen twice
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      dst_pulse <= 1'b0;
      dst_data <= '0;
    end else begin
      dst_pulse <= s2_r ^ s3_r;
      if (s2_r ^ s3_r) begin
        dst_data <= hold_r;
      end
    end
  end
endmodule // hmw_evt_xfer
`default_nettype wire

// >>> hdl/hmw_top.sv
// Host memory window mailbox: host registers on the link clock, memory port on ref_clk.
// Assumes a single-cycle host strobe interface and memory data one cycle after mem_req.
`timescale 1ns/1ps
`default_nettype none
`include "hmw_defines.svh"
module hmw_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic lpc_clk,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [3:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic host_busy,
  output logic host_event_n,
  output logic host_software_event,
  output logic host_ec_irq,
  output logic host_low_power,
  input wire hmw_pkg::hmw_region_s [1:0] region_cfg,
  input wire logic ctl_c2h_wr,
  input wire logic [7:0] ctl_c2h_data,
  input wire logic ctl_swi_wr,
  input wire logic [15:0] ctl_swi_set,
  output logic ctl_h2c_irq,
  output logic [7:0] ctl_h2c_mbox,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata
);

  // Lanes touched in memory for one host data byte access
  function automatic logic [3:0] lanes(input logic we, input logic [1:0] at,
                                       input logic [1:0] lane);
    logic [3:0] be;
    be = `HMW_BE_NONE;
    if (at == `HMW_AT_BYTE) begin
      be = `HMW_BE_ONE << lane;
    end else if (at == `HMW_AT_HALF) begin
      if (!we && lane == `HMW_LANE_0) be = `HMW_BE_LOW;
      if (!we && lane == `HMW_LANE_2) be = `HMW_BE_HIGH;
      if (we && lane == `HMW_LANE_1) be = `HMW_BE_LOW;
      if (we && lane == `HMW_LANE_3) be = `HMW_BE_HIGH;
    end else begin
      if (!we && lane == `HMW_LANE_0) be = `HMW_BE_ALL;
      if (we && lane == `HMW_LANE_3) be = `HMW_BE_ALL;
    end
    return be;
  endfunction

  // Region test on the controller clock, limits in bytes from the base
  function automatic logic allowed(input hmw_pkg::hmw_region_s cfg, input logic we,
                                   input logic [12:0] word);
    logic [14:0] off;
    off = {word, 2'b00};
    if (!cfg.en) return 1'b0;
    return we ? (off < cfg.wr_limit) : (off < cfg.rd_limit);
  endfunction

  // Link-side reset and state
  logic lrst;
  logic [15:0] addr_r, src_r, mask_r, swi_bits;
  logic [31:0] data_r;
  logic [7:0] appid_r, h2c_r, c2h_mbox;
  logic busy_r, pend_rd_r, pend_inc_r;
  logic [1:0] pend_lane_r;
  logic [3:0] pend_be_r;
  logic c2h_pulse, swi_pulse, rsp_pulse;
  hmw_pkg::hmw_rsp_s rsp_in;
  // Link-side decode
  logic [1:0] lane, at;
  logic is_data, acc, req_go;
  logic [3:0] be_now;
  logic [31:0] data_wr, data_ld;
  hmw_pkg::hmw_req_s req_nxt;

  hmw_sync_bit u_rst_sync (
    .clk(lpc_clk),
    .d(rst),
    .q(lrst)
  );

  // Busy refuses new host accesses until the memory answer is back
  always_comb begin
    lane = host_addr[1:0];
    at = addr_r[`HMW_AT_MSB:0];
    is_data = (host_addr[3:2] == `HMW_OFF_DATA);
    acc = (host_wr | host_rd) & ~busy_r;
    be_now = lanes(host_wr, at, lane);
    req_go = acc & is_data & (be_now != `HMW_BE_NONE);
    data_wr = data_r;
    data_wr[lane*8 +: 8] = host_wdata;
    req_nxt.we = host_wr;
    req_nxt.region = addr_r[`HMW_REGION_BIT];
    req_nxt.word = addr_r[`HMW_WORD_MSB:`HMW_WORD_LSB];
    req_nxt.be = be_now;
    req_nxt.wdata = host_wr ? data_wr : data_r;
    data_ld = data_r;
    for (int i = 0; i < 4; i++) begin
      if (pend_be_r[i]) data_ld[i*8 +: 8] = rsp_in.rdata[i*8 +: 8];
    end
  end

  // Outstanding memory transfer bookkeeping
  always_ff @(posedge lpc_clk) begin
    if (lrst) begin
      busy_r <= 1'b0;
      pend_rd_r <= 1'b0;
      pend_inc_r <= 1'b0;
      pend_lane_r <= `HMW_LANE_0;
      pend_be_r <= `HMW_BE_NONE;
    end else if (req_go) begin
      busy_r <= 1'b1;
      pend_rd_r <= host_rd;
      pend_inc_r <= host_wr & (at == `HMW_AT_AUTO) & (lane == `HMW_LANE_3);
      pend_lane_r <= lane;
      pend_be_r <= be_now;
    end else if (rsp_pulse) begin
      busy_r <= 1'b0;
    end
  end

  // Data register: host byte writes, then memory loads on an allowed read
  always_ff @(posedge lpc_clk) begin
    if (lrst) begin
      data_r <= `HMW_RST_WORD;
    end else if (acc & host_wr & is_data) begin
      data_r <= data_wr;
    end else if (rsp_pulse & pend_rd_r & rsp_in.ok) begin
      data_r <= data_ld;
    end
  end

  // Address register with auto-increment; refused writes do not advance it
  always_ff @(posedge lpc_clk) begin
    if (lrst) begin
      addr_r <= `HMW_RST_HALF;
    end else if (acc & host_wr & (host_addr == `HMW_OFF_ADDR_LO)) begin
      addr_r[7:0] <= host_wdata;
    end else if (acc & host_wr & (host_addr == `HMW_OFF_ADDR_HI)) begin
      addr_r[15:8] <= host_wdata;
    end else if ((acc & host_rd & is_data & (at == `HMW_AT_AUTO) & (lane == `HMW_LANE_3))
                 | (rsp_pulse & pend_inc_r & rsp_in.ok)) begin
      addr_r[`HMW_WORD_MSB:`HMW_WORD_LSB] <=
        addr_r[`HMW_WORD_MSB:`HMW_WORD_LSB] + `HMW_WORD_ONE;
    end
  end

  // Plain host registers: mailbox copy, application id, mask
  always_ff @(posedge lpc_clk) begin
    if (lrst) begin
      h2c_r <= `HMW_RST_BYTE;
      appid_r <= `HMW_RST_BYTE;
      mask_r <= `HMW_RST_HALF;
    end else if (acc & host_wr) begin
      if (host_addr == `HMW_OFF_H2C) h2c_r <= host_wdata;
      if (host_addr == `HMW_OFF_APPID) appid_r <= host_wdata;
      if (host_addr == `HMW_OFF_MASK_LO) mask_r[7:0] <= host_wdata;
      if (host_addr == `HMW_OFF_MASK_HI) mask_r[15:8] <= host_wdata;
    end
  end

  // Interrupt sources: host writes ones to clear, a set in the same cycle wins
  always_ff @(posedge lpc_clk) begin
    if (lrst) begin
      src_r <= `HMW_RST_HALF;
    end else begin
      src_r <= (src_r & ~({(acc & host_wr & (host_addr == `HMW_OFF_SRC_HI)) ? host_wdata
                                                                             : 8'h00,
                           (acc & host_wr & (host_addr == `HMW_OFF_SRC_LO)) ? host_wdata
                                                                             : 8'h00}))
               | ({16{swi_pulse}} & {swi_bits[15:1], 1'b0})
               | {15'h0000, c2h_pulse};
    end
  end

  // Host read answers: one clock for registers, answer arrival for fetches
  always_ff @(posedge lpc_clk) begin
    if (lrst) begin
      host_rdata <= `HMW_RST_BYTE;
      host_rvalid <= 1'b0;
    end else if (rsp_pulse & pend_rd_r) begin
      host_rdata <= rsp_in.ok ? data_ld[pend_lane_r*8 +: 8] : data_r[pend_lane_r*8 +: 8];
      host_rvalid <= 1'b1;
    end else if (acc & host_rd & ~req_go) begin
      host_rvalid <= 1'b1;
      unique case (host_addr)
        `HMW_OFF_H2C: host_rdata <= h2c_r;
        `HMW_OFF_C2H: host_rdata <= c2h_mbox;
        `HMW_OFF_ADDR_LO: host_rdata <= addr_r[7:0];
        `HMW_OFF_ADDR_HI: host_rdata <= addr_r[15:8];
        `HMW_OFF_SRC_LO: host_rdata <= src_r[7:0];
        `HMW_OFF_SRC_HI: host_rdata <= src_r[15:8];
        `HMW_OFF_MASK_LO: host_rdata <= mask_r[7:0];
        `HMW_OFF_MASK_HI: host_rdata <= mask_r[15:8];
        `HMW_OFF_APPID: host_rdata <= appid_r;
        default: host_rdata <= is_data ? data_r[lane*8 +: 8] : `HMW_RST_BYTE;
      endcase
    end else begin
      host_rvalid <= 1'b0;
    end
  end

  // Event pins and status outputs, all one clock behind their sources
  always_ff @(posedge lpc_clk) begin
    if (lrst) begin
      host_event_n <= 1'b1;
      host_software_event <= 1'b0;
      host_ec_irq <= 1'b0;
      host_low_power <= 1'b1;
      host_busy <= 1'b0;
    end else begin
      host_ec_irq <= src_r[`HMW_SRC_ECWR] & mask_r[`HMW_SRC_ECWR];
      host_software_event <= |(src_r & mask_r);
      host_event_n <= ~(|(src_r & mask_r));
      host_low_power <= ~(host_wr | host_rd | busy_r | req_go);
      host_busy <= req_go | (busy_r & ~rsp_pulse);
    end
  end

  // Crossings between the link and controller clocks
  hmw_pkg::hmw_req_s req_in;
  hmw_pkg::hmw_rsp_s rsp_r;
  hmw_pkg::hmw_mem_e state_r;
  logic req_pulse, h2c_pulse;
  logic [7:0] h2c_data;

  hmw_evt_xfer #(.W($bits(hmw_pkg::hmw_req_s))) u_req_xfer (
    .src_clk(lpc_clk), .src_rst(lrst), .src_pulse(req_go), .src_data(req_nxt),
    .dst_clk(ref_clk), .dst_rst(rst), .dst_pulse(req_pulse), .dst_data(req_in)
  );
  hmw_evt_xfer #(.W($bits(hmw_pkg::hmw_rsp_s))) u_rsp_xfer (
    .src_clk(ref_clk), .src_rst(rst), .src_pulse(state_r == hmw_pkg::HMW_REPLY),
    .src_data(rsp_r), .dst_clk(lpc_clk), .dst_rst(lrst), .dst_pulse(rsp_pulse),
    .dst_data(rsp_in)
  );
  hmw_evt_xfer #(.W(8)) u_h2c_xfer (
    .src_clk(lpc_clk), .src_rst(lrst),
    .src_pulse(acc & host_wr & (host_addr == `HMW_OFF_H2C)), .src_data(host_wdata),
    .dst_clk(ref_clk), .dst_rst(rst), .dst_pulse(h2c_pulse), .dst_data(h2c_data)
  );
  hmw_evt_xfer #(.W(8)) u_c2h_xfer (
    .src_clk(ref_clk), .src_rst(rst), .src_pulse(ctl_c2h_wr), .src_data(ctl_c2h_data),
    .dst_clk(lpc_clk), .dst_rst(lrst), .dst_pulse(c2h_pulse), .dst_data(c2h_mbox)
  );
  hmw_evt_xfer #(.W(16)) u_swi_xfer (
    .src_clk(ref_clk), .src_rst(rst), .src_pulse(ctl_swi_wr), .src_data(ctl_swi_set),
    .dst_clk(lpc_clk), .dst_rst(lrst), .dst_pulse(swi_pulse), .dst_data(swi_bits)
  );

  // Controller mailbox side: interrupt pulse and readable copy
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_h2c_irq <= 1'b0;
      ctl_h2c_mbox <= `HMW_RST_BYTE;
    end else begin
      ctl_h2c_irq <= h2c_pulse;
      if (h2c_pulse) ctl_h2c_mbox <= h2c_data;
    end
  end

  // Memory sequencer: one access per request, refused ones skip memory
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= hmw_pkg::HMW_IDLE;
      rsp_r <= '0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `HMW_RST_WORD;
      mem_be <= `HMW_BE_NONE;
      mem_wdata <= `HMW_RST_WORD;
    end else begin
      unique case (state_r)
        hmw_pkg::HMW_IDLE: begin
          if (req_pulse) begin
            if (allowed(region_cfg[req_in.region], req_in.we, req_in.word)) begin
              mem_req <= 1'b1;
              mem_we <= req_in.we;
              mem_addr <= region_cfg[req_in.region].base + {17'h00000, req_in.word, 2'b00};
              mem_be <= req_in.be;
              mem_wdata <= req_in.wdata;
              rsp_r.ok <= 1'b1;
              state_r <= hmw_pkg::HMW_ACCESS;
            end else begin
              rsp_r.ok <= 1'b0;
              state_r <= hmw_pkg::HMW_REPLY;
            end
          end
        end
        hmw_pkg::HMW_ACCESS: begin
          mem_req <= 1'b0;
          state_r <= hmw_pkg::HMW_CAPT;
        end
        hmw_pkg::HMW_CAPT: begin
          rsp_r.rdata <= mem_rdata;
          state_r <= hmw_pkg::HMW_REPLY;
        end
        hmw_pkg::HMW_REPLY: begin
          state_r <= hmw_pkg::HMW_IDLE;
        end
      endcase
    end
  end

  // Checks on the link clock
  a_event_pin: assert property (@(posedge lpc_clk) disable iff (lrst)
    (src_r & mask_r) != 16'h0000 |=> !host_event_n) else $error("event pin wrong");
  a_ec_irq: assert property (@(posedge lpc_clk) disable iff (lrst)
    (src_r[0] && mask_r[0]) |=> host_ec_irq) else $error("host irq missing");
  a_swi_mask: assert property (@(posedge lpc_clk) disable iff (lrst)
    (src_r[15:1] & mask_r[15:1]) == 15'h0000 && !(src_r[0] && mask_r[0])
    |=> !host_software_event && host_event_n) else $error("masked source raised event");
  a_plain_read: assert property (@(posedge lpc_clk) disable iff (lrst)
    (host_rd && !busy_r && !is_data) |=> host_rvalid) else $error("register read late");
  a_fetch_busy: assert property (@(posedge lpc_clk) disable iff (lrst)
    req_go |=> host_busy && busy_r) else $error("fetch did not go busy");
  a_auto_inc: assert property (@(posedge lpc_clk) disable iff (lrst)
    (acc && host_rd && is_data && at == `HMW_AT_AUTO && lane == `HMW_LANE_3)
    |=> addr_r[14:2] == $past(addr_r[14:2]) + 13'h0001) else $error("no auto increment");
  a_word_store: assert property (@(posedge lpc_clk) disable iff (lrst)
    (acc && host_wr && is_data && at == `HMW_AT_WORD && lane == `HMW_LANE_3)
    |-> req_go && be_now == 4'hf) else $error("word store missing");
  a_wake: assert property (@(posedge lpc_clk) disable iff (lrst)
    (host_wr || host_rd) |=> !host_low_power) else $error("stayed in low power");

  // Checks on the controller clock
  a_refused_skip: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hmw_pkg::HMW_IDLE && req_pulse
     && !allowed(region_cfg[req_in.region], req_in.we, req_in.word))
    |=> !mem_req ##1 !mem_req) else $error("refused access reached memory");
  a_mem_single: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(mem_req) |=> !mem_req ##1 state_r == hmw_pkg::HMW_REPLY)
    else $error("memory access not single");

endmodule // hmw_top
`default_nettype wire

// >>> sim/hmw_mem_model.sv
// Controller memory model answering the window's memory port.
// Assumes read data is taken one ref_clk cycle after mem_req.
`timescale 1ns/1ps
`default_nettype none
module hmw_mem_model (
  input wire logic ref_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic hold_r;
  // Distinct pattern per word so a wrong word shows
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = {4{i[7:0]}} ^ 32'h3c5a_96e1;
  end
  // Read data stands one cycle, then scrambled so a late sample fails
  always @(posedge ref_clk) begin
    hold_r <= mem_req && !mem_we;
    if (mem_req && mem_we) begin
      for (int b = 0; b < 4; b++) begin
        if (mem_be[b]) mem[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
      end
    end
    if (mem_req && !mem_we) mem_rdata <= mem[mem_addr[9:2]];
    else if (hold_r) mem_rdata <= ~mem_rdata;
  end
endmodule // hmw_mem_model
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the host memory window mailbox.
// Assumes hmw_top and the memory model; host on lpc_clk, controller on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 0, lpc_clk = 0, rst = 1, host_wr = 0, host_rd = 0;
  logic [3:0] host_addr = 0;
  logic [7:0] host_wdata = 0, host_rdata, ctl_h2c_mbox, v;
  logic host_rvalid, host_busy, host_event_n, host_software_event, host_ec_irq;
  logic host_low_power, ctl_h2c_irq, mem_req, mem_we, ctl_c2h_wr = 0, ctl_swi_wr = 0;
  logic [15:0] ctl_swi_set = 0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, w, x;
  logic [3:0] mem_be;
  hmw_pkg::hmw_region_s [1:0] region_cfg = '0;
  logic [7:0] exp_q[$];
  int n_errors = 0, cmp_count = 0, irq_cnt = 0;
  // Clocks: posedges never coincide
  always #4 ref_clk = ~ref_clk;
  always #6 lpc_clk = ~lpc_clk;
  hmw_top uut (.ref_clk(ref_clk), .rst(rst), .lpc_clk(lpc_clk), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .host_busy(host_busy),
    .host_event_n(host_event_n), .host_software_event(host_software_event),
    .host_ec_irq(host_ec_irq), .host_low_power(host_low_power), .region_cfg(region_cfg),
    .ctl_c2h_wr(ctl_c2h_wr), .ctl_c2h_data(ctl_swi_set[7:0]), .ctl_swi_wr(ctl_swi_wr),
    .ctl_swi_set(ctl_swi_set), .ctl_h2c_irq(ctl_h2c_irq), .ctl_h2c_mbox(ctl_h2c_mbox),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  hmw_mem_model mm (.ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One host access; waits out a memory transfer under a bound
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge lpc_clk) #1;
    host_wr = wr;
    host_rd = !wr;
    host_addr = a;
    host_wdata = d;
    @(posedge lpc_clk) #1;
    host_wr = 0;
    host_rd = 0;
    @(posedge lpc_clk) #1;
    n = 0;
    while (host_busy !== 1'b0 && n < 40) begin
      @(posedge lpc_clk) #1;
      n++;
    end
    if (n == 40) chk("busy", host_busy, 0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(0, a, 8'h00);
  endtask
  task automatic set_addr(input logic r, input logic [12:0] wd, input logic [1:0] s);
    acc(1, 4'h2, {wd[5:0], s});
    acc(1, 4'h3, {r, wd[12:6]});
  endtask
  task automatic wr4(input logic [31:0] d);
    for (int b = 0; b < 4; b++) acc(1, 4'h4 + 4'(b), d[8*b +: 8]);
  endtask
  // Controller pulse, then time for the crossing to settle
  task automatic ctl(input logic c2h, input logic [15:0] d);
    @(posedge ref_clk) #1;
    ctl_c2h_wr = c2h;
    ctl_swi_wr = !c2h;
    ctl_swi_set = d;
    @(posedge ref_clk) #1;
    ctl_c2h_wr = 0;
    ctl_swi_wr = 0;
    repeat (12) @(posedge lpc_clk);
  endtask
  task automatic evt(input logic e, input logic ec);
    repeat (8) @(posedge lpc_clk) #1;
    chk("event_n", host_event_n, !e);
    chk("swi_event", host_software_event, e);
    chk("ec_irq", host_ec_irq, ec);
  endtask
  // Read answers are taken off the queue in the cycle they stand
  always @(posedge lpc_clk) begin
    if (host_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("rvalid", 1, 0);
      else chk("rdata", host_rdata, exp_q.pop_front());
    end
  end
  always @(posedge ref_clk) if (ctl_h2c_irq === 1'b1) irq_cnt++;
  // Hang guard, far beyond the expected run
  initial begin
    #300000;
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h43bd));
    region_cfg[0] = '{1'b1, 32'h0, 15'h0100, 15'h0100};
    region_cfg[1] = '{1'b1, 32'h200, 15'h0000, 15'h0040};
    repeat (4) @(posedge lpc_clk);
    chk("rst_event_n", host_event_n, 1);
    chk("rst_lowpow", host_low_power, 1);
    chk("rst_busy", {host_busy, host_rvalid, ctl_h2c_irq, mem_req}, 0);
    @(posedge ref_clk) #1;
    rst = 0;
    repeat (4) @(posedge lpc_clk);
    v = 8'($urandom);
    acc(1, 4'hc, v);
    rd(4'hc, v);
    v = 8'($urandom);
    acc(1, 4'h0, v);
    repeat (10) @(posedge lpc_clk);
    chk("h2c_irq", irq_cnt, 1);
    chk("h2c_mbox", ctl_h2c_mbox, v);
    ctl(1, {8'h00, ~v});
    rd(4'h1, ~v);
    rd(4'h8, 8'h01);
    evt(0, 0);
    acc(1, 4'ha, 8'h01);
    evt(1, 1);
    acc(1, 4'h8, 8'h01);
    evt(0, 0);
    ctl(0, 16'h0020);
    rd(4'h8, 8'h20);
    evt(0, 0);
    acc(1, 4'ha, 8'h20);
    rd(4'ha, 8'h20);
    evt(1, 0);
    acc(1, 4'h8, 8'h20);
    evt(0, 0);
    set_addr(0, 13'h2, 2'h2);
    rd(4'h2, 8'h0a);
    w = mm.mem[2];
    for (int b = 0; b < 4; b++) rd(4'h4 + 4'(b), w[8*b +: 8]);
    x = $urandom;
    for (int b = 0; b < 3; b++) acc(1, 4'h4 + 4'(b), x[8*b +: 8]);
    chk("word_nostore", mm.mem[2], w);
    acc(1, 4'h7, x[31:24]);
    chk("word_store", mm.mem[2], x);
    set_addr(0, 13'h8, 2'h1);
    w = mm.mem[8];
    rd(4'h6, w[23:16]);
    rd(4'h7, w[31:24]);
    x = $urandom;
    acc(1, 4'h4, x[7:0]);
    acc(1, 4'h5, x[15:8]);
    chk("half_store", mm.mem[8], {w[31:16], x[15:0]});
    set_addr(0, 13'h9, 2'h0);
    w = mm.mem[9];
    acc(1, 4'h5, x[23:16]);
    chk("byte_store", mm.mem[9], {w[31:16], x[23:16], w[7:0]});
    rd(4'h6, w[23:16]);
    set_addr(0, 13'h4, 2'h3);
    w = mm.mem[4];
    for (int b = 0; b < 4; b++) rd(4'h4 + 4'(b), w[8*b +: 8]);
    w = mm.mem[5];
    rd(4'h4, w[7:0]);
    wr4(x);
    chk("auto_store", mm.mem[5], x);
    w = mm.mem[6];
    rd(4'h4, w[7:0]);
    set_addr(1, 13'h0, 2'h2);
    x = $urandom;
    wr4(x);
    chk("wonly_store", mm.mem[128], x);
    rd(4'h4, x[7:0]);
    set_addr(0, 13'h50, 2'h2);
    w = mm.mem[8'h50];
    wr4(~x);
    chk("out_nostore", mm.mem[8'h50], w);
    rd(4'h4, ~x[7:0]);
    repeat (10) @(posedge lpc_clk);
    chk("pending", exp_q.size(), 0);
    chk("idle_lowpow", host_low_power, 1);
    conclude();
  end
endmodule // tb
`default_nettype wire
